// file: rtl/fcb_flash_ctrl.sv
/*
 Program flash array with its configuration byte, fetch path and write sequencer.
 Assumes the core clock and reset are the device's own and pins are synchronous.
 // How it works
 // - Flash split into 128-byte pages
 // - Every write erases its target first
 // - Erase-and-program lasts about 10 ms
 // - Reads return a byte, no wait
 // - External access low selects external code
 // - Double-speed bit zero selects six-clock mode
 // - Boot bit zero starts loader at F800
 // - Aux RAM bit programmed inhibits aux RAM
 // - Config byte only through parallel programmer
 // - Aux RAM and lock bits programmer-only
 // - Extra page outside program address space
 // - Loader downloads come over the UART
 // - Software writes enter through boot ROM entry
 // - Three lock bits choose protection level
 // - Level four also blocks external execution
*/
`timescale 1ns/100ps
module fcb_flash_ctrl
    import fcb_pkg::*;
#(
    parameter int PAGES = PAGES_32K,
    parameter int PROG_CYC = PROG_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Code fetch port
    input wire logic [15:0] fetch_addr,
    input wire logic fetch_en,
    output logic [7:0] fetch_data,
    output logic fetch_external,
    output logic fetch_blocked,
    // Pins
    input wire logic external_access_pin_b,
    // Write requests
    input wire logic req_valid,
    input wire logic [1:0] req_cmd,
    input wire logic [1:0] req_src,
    input wire logic [15:0] req_pc,
    input wire logic [15:0] req_addr,
    input wire logic [7:0] req_data,
    input wire logic [6:0] page_idx,
    output logic req_ready,
    output logic req_done,
    output logic req_error,
    // Page load buffer write
    input wire logic pbuf_we,
    input wire logic [6:0] pbuf_addr,
    input wire logic [7:0] pbuf_data,
    // Parallel programmer read of config and code
    input wire logic par_mode,
    input wire logic par_verify,
    output logic [7:0] par_rdata,
    // Config outputs
    output logic [7:0] hardware_security_config,
    output logic double_speed_mode,
    output logic [15:0] boot_addr,
    output logic aux_ram_enable,
    output logic [2:0] lock_level
);
    localparam int AW = $clog2(PAGES * PAGE_BYTES);
    localparam int DEPTH = PAGES * PAGE_BYTES;

    // States
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUSY = 3'b010,
        ST_DONE = 3'b100
    } fcb_state_t;

    logic [7:0] mem [DEPTH]; // Flash array, no reset
    logic [7:0] pbuf [PAGE_BYTES]; // Page load buffer
    // Nonvolatile config byte; starts at the erased default, so the first sample is never unknown
    logic [7:0] cfg_nv_r = CFG_DEFAULT;
    logic [7:0] cfg_r; // Sampled config
    logic sampled_r; // Sample taken since reset
    logic ea_latch_r; // Pin value latched at reset
    fcb_state_t st_r, st_nxt;
    logic [1:0] cmd_r;
    logic [15:0] addr_r;
    logic [7:0] data_r;
    logic [6:0] page_r;
    logic [7:0] fetch_data_r;
    logic [7:0] par_rdata_r;
    logic done_r, err_r;
    fcb_timer_if tif();

    fcb_op_timer #(.CYCLES(PROG_CYC)) u_tmr (
        .clock(clock),
        .rst_b(rst_b),
        .tif(tif)
    );

    // Decoded settings
    wire [2:0] lvl = fcb_lock_level(cfg_r[LOCK_HI:0]);
    wire ea_eff = (lvl >= LOCK_LVL2) ? ea_latch_r : external_access_pin_b;
    wire internal_hit = ea_eff && ({16'h0, fetch_addr} < 32'(DEPTH));
    wire ext_fetch = !internal_hit;
    wire ext_block = ext_fetch && (lvl == LOCK_LVL4);
    // Programmer writes blocked from level 2; verify from level 3
    wire par_wr_block = (lvl >= LOCK_LVL2);
    wire par_rd_block = (lvl >= LOCK_LVL3);
    // Software writes must come from the boot ROM entry point
    wire api_ok = (req_pc == ROM_ENTRY_ADDR);
    // ISP loader runs from boot ROM and takes UART data from any PC at or above BOOT_LOADER_ADDR
    wire isp_ok = (req_pc >= BOOT_LOADER_ADDR);
    wire src_ok = (req_src == SRC_PAR) ? !par_wr_block :
                  (req_src == SRC_ISP) ? isp_ok : api_ok;
    // Config byte writes only from the programmer
    wire cfg_ok = (req_src == SRC_PAR) && par_mode;
    wire cmd_ok = (req_cmd == CMD_CFG) ? cfg_ok :
                  (req_cmd == CMD_BYTE || req_cmd == CMD_PAGE) && src_ok;
    wire take = req_valid && (st_r == ST_IDLE);

    assign req_ready = (st_r == ST_IDLE);
    assign tif.start = take && cmd_ok;
    assign req_done = done_r;
    assign req_error = err_r;
    assign fetch_data = fetch_data_r;
    assign fetch_external = ext_fetch;
    assign fetch_blocked = ext_block;
    assign par_rdata = par_rdata_r;
    assign hardware_security_config = cfg_r;
    assign double_speed_mode = !cfg_r[DOUBLE_SPEED_BIT];
    assign boot_addr = cfg_r[BOOT_SELECT_BIT] ? BOOT_APP_ADDR : BOOT_LOADER_ADDR;
    assign aux_ram_enable = cfg_r[AUX_RAM_BIT];
    assign lock_level = lvl;

    // Sequencer next state
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: if (take && cmd_ok) st_nxt = ST_BUSY;
            ST_BUSY: if (tif.done) st_nxt = ST_DONE;
            ST_DONE: st_nxt = ST_IDLE;
            default: st_nxt = ST_IDLE;
        endcase
    end

    // Control registers; config captured once after reset release
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= ST_IDLE;
            cfg_r <= CFG_DEFAULT;
            sampled_r <= 1'b0;
            ea_latch_r <= 1'b1;
            cmd_r <= 2'h0;
            addr_r <= 16'h0;
            data_r <= 8'h0;
            page_r <= 7'h0;
            done_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if (!sampled_r) begin
                cfg_r <= cfg_nv_r;
                ea_latch_r <= external_access_pin_b;
                sampled_r <= 1'b1;
            end
            if (take) begin
                cmd_r <= req_cmd;
                addr_r <= req_addr;
                data_r <= req_data;
                page_r <= page_idx;
            end
            done_r <= (st_r == ST_BUSY) && tif.done;
            err_r <= take && !cmd_ok;
        end
    end

    // Nonvolatile config storage, survives reset; written by programmer only
    always_ff @(posedge clock) begin
        if (st_r == ST_BUSY && tif.done && cmd_r == CMD_CFG) begin
            cfg_nv_r <= data_r;
        end
    end

    // Page buffer load
    always_ff @(posedge clock) begin
        if (pbuf_we) begin
            pbuf[pbuf_addr] <= pbuf_data;
        end
    end

    // Array commit at the end of the timed cycle: erase and program in one step
    always_ff @(posedge clock) begin
        if (st_r == ST_BUSY && tif.done) begin
            if (cmd_r == CMD_BYTE) begin
                mem[addr_r[AW-1:0]] <= data_r;
            end else if (cmd_r == CMD_PAGE) begin
                for (int i = 0; i < PAGE_BYTES; i++) begin
                    // Page index widened to the array address on purpose
                    mem[AW'({page_r, 7'(i)})] <= pbuf[i];
                end
            end
        end
    end

    // Fetch: one byte each cycle, no wait; extra page never decoded here
    always_ff @(posedge clock) begin
        if (fetch_en) begin
            fetch_data_r <= internal_hit ? mem[fetch_addr[AW-1:0]] : 8'h00;
        end
        par_rdata_r <= par_mode ? (par_verify ? (par_rd_block ? 8'hFF :
                       mem[req_addr[AW-1:0]]) : cfg_r) : 8'h00;
    end
endmodule : fcb_flash_ctrl

// file: rtl/fcb_pkg.sv
/*
 Package for the flash controller and configuration byte block.
 Holds geometry, configuration byte layout, reset/default values and timing counts.
 Assumes a single 25 MHz clock.
*/
package fcb_pkg;
    // Clock rate
    localparam int CLK_HZ = 25000000;
    // Flash geometry
    localparam int PAGE_BYTES = 128;
    localparam int PAGES_16K = 128;
    localparam int PAGES_32K = 256;
    localparam int EXT_SPACE_BYTES = 65536;
    // Configuration byte field positions
    localparam int DOUBLE_SPEED_BIT = 7;
    localparam int BOOT_SELECT_BIT = 6;
    localparam int AUX_RAM_BIT = 3;
    localparam int LOCK_HI = 2;
    // Default configuration byte after chip erase (lock level 4, loader boot)
    localparam logic [7:0] CFG_DEFAULT = 8'hBB;
    // Boot addresses
    localparam logic [15:0] BOOT_LOADER_ADDR = 16'hF800;
    localparam logic [15:0] BOOT_APP_ADDR = 16'h0000;
    // Boot ROM common entry point for flash routines
    localparam logic [15:0] ROM_ENTRY_ADDR = 16'hFFF0;
    // Erase-and-program time in microseconds, and its cycle count
    localparam int PROG_TIME_US = 10000;
    localparam int PROG_CYCLES = (CLK_HZ / 1000000) * PROG_TIME_US;
    // Command codes on the flash request port
    localparam logic [1:0] CMD_BYTE = 2'h1;
    localparam logic [1:0] CMD_PAGE = 2'h2;
    localparam logic [1:0] CMD_CFG = 2'h3;
    // Requester codes
    localparam logic [1:0] SRC_PAR = 2'h0;
    localparam logic [1:0] SRC_ISP = 2'h1;
    localparam logic [1:0] SRC_API = 2'h2;
    // Lock levels
    localparam logic [2:0] LOCK_LVL1 = 3'h1;
    localparam logic [2:0] LOCK_LVL2 = 3'h2;
    localparam logic [2:0] LOCK_LVL3 = 3'h3;
    localparam logic [2:0] LOCK_LVL4 = 3'h4;

    // Lock level from three lock bits (programmed = 0), bit2 strongest
    function automatic logic [2:0] fcb_lock_level(input logic [2:0] lb);
        if (!lb[2]) fcb_lock_level = LOCK_LVL4;
        else if (!lb[1]) fcb_lock_level = LOCK_LVL3;
        else if (!lb[0]) fcb_lock_level = LOCK_LVL2;
        else fcb_lock_level = LOCK_LVL1;
    endfunction : fcb_lock_level
endpackage : fcb_pkg

// file: rtl/fcb_timer_if.sv
/*
 Interface between the flash controller and its operation timer.
 Assumes both ends share the block clock.
*/
`timescale 1ns/100ps
interface fcb_timer_if;
    logic start; // One-cycle start pulse
    logic busy; // Timer running
    logic done; // One-cycle end pulse
    modport ctrl (output start, input busy, input done);
    modport timer (input start, output busy, output done);
endinterface : fcb_timer_if

// file: rtl/fcb_op_timer.sv
/*
 Erase-and-program duration timer.
 Assumes a start pulse only while idle; a start while busy is ignored.
*/
`timescale 1ns/100ps
module fcb_op_timer
    import fcb_pkg::*;
#(
    parameter int CYCLES = PROG_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Controller side
    fcb_timer_if.timer tif
);
    logic [31:0] cnt_r; // Cycles left
    logic [31:0] cnt_nxt;
    logic done_r; // End pulse
    logic done_nxt;

    // Load on start, count to zero
    assign cnt_nxt = (tif.start && cnt_r == 32'h0) ? 32'(CYCLES) :
                     (cnt_r != 32'h0) ? cnt_r - 32'h1 : 32'h0;
    assign done_nxt = (cnt_r == 32'h1);
    assign tif.busy = (cnt_r != 32'h0);
    assign tif.done = done_r;

    // Counter registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 32'h0;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end
endmodule : fcb_op_timer

// file: verification/fcb_flash_ctrl_monitor.sv
/* Port checker for the flash controller.
 Assumes one clock domain and a bind onto fcb_flash_ctrl. */
`timescale 1ns/100ps
module fcb_flash_ctrl_monitor
    import fcb_pkg::*;
#(parameter int PROG_CYC = 8) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Request handshake
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_done,
    input wire logic req_error,
    // Fetch routing
    input wire logic fetch_external,
    input wire logic fetch_blocked,
    input wire logic external_access_pin_b,
    // Sampled configuration
    input wire logic [7:0] hardware_security_config,
    input wire logic double_speed_mode,
    input wire logic [15:0] boot_addr,
    input wire logic aux_ram_enable,
    input wire logic [2:0] lock_level
);
    // Busy span from the cycle after the take to done
    localparam int DONE_LAG = PROG_CYC + 1;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_take; req_valid && req_ready; endsequence
    // Accepted means busy and no refusal one cycle on
    sequence s_accept; s_take ##1 (!req_ready && !req_error); endsequence
    a_done_lag: assert property (s_accept |-> ##DONE_LAG req_done)
        else $error("done not on time");
    a_error_once: assert property (req_error |=> !req_error && req_ready)
        else $error("error pulse too long");
    a_done_once: assert property (req_done |=> !req_done && req_ready)
        else $error("done pulse too long");
    a_speed_map: assert property (double_speed_mode == !hardware_security_config[7])
        else $error("speed mode wrong");
    a_boot_map: assert property (boot_addr == (hardware_security_config[6] ? 16'h0000 : 16'hF800))
        else $error("boot address wrong");
    a_aux_map: assert property (aux_ram_enable == hardware_security_config[3])
        else $error("aux ram enable wrong");
    // Two edges past release the loaded value must stay put
    a_cfg_hold: assert property (rst_b && $past(rst_b, 2) |-> $stable(hardware_security_config))
        else $error("config changed without reset");
    a_lock_ext: assert property (fetch_blocked == (fetch_external && lock_level == LOCK_LVL4))
        else $error("external block wrong");
    // From level 2 the pin is latched at reset, so only level 1 follows the live pin
    a_pin_ext: assert property (!external_access_pin_b && lock_level == LOCK_LVL1 |-> fetch_external)
        else $error("pin low not external");
endmodule : fcb_flash_ctrl_monitor
bind fcb_flash_ctrl fcb_flash_ctrl_monitor #(.PROG_CYC(PROG_CYC)) mon_u (.clock, .rst_b,
    .req_valid, .req_ready, .req_done, .req_error, .fetch_external, .fetch_blocked,
    .external_access_pin_b, .hardware_security_config, .double_speed_mode, .boot_addr,
    .aux_ram_enable, .lock_level);

// file: verification/fcb_programmer_model.sv
/* Programmer and loader host on the request port.
 Assumes the bench clock; drives on the falling edge. */
`timescale 1ns/100ps
module fcb_programmer_model (
    // Clock and answers
    input wire logic clock,
    input wire logic req_ready,
    input wire logic req_done,
    input wire logic req_error,
    // Request lines
    output logic req_valid,
    output logic [50:0] req_bus
);
    initial req_valid = 1'b0;
    initial req_bus = '0;
    // One request; res 1 done, 2 refused, 0 no answer; lat edges after take
    task automatic send(input logic [50:0] r, output int res, output int lat);
        int n;
        res = 0;
        lat = 0;
        @(negedge clock);
        for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge clock);
        req_bus = r;
        req_valid = 1'b1;
        @(negedge clock);
        req_valid = 1'b0;
        // Released lines show the inverse, never a stale copy
        req_bus = ~r;
        // Answers are looked at on falling edges, where they are settled
        for (n = 0; n < 50 && res == 0; n++) begin
            if (req_done === 1'b1) res = 1;
            else if (req_error === 1'b1) res = 2;
            lat = n + 1;
            if (res == 0) @(negedge clock);
        end
    endtask : send
endmodule : fcb_programmer_model

// file: verification/flash_memory_config_byte_tb_top.sv
/* Self-checking bench for the flash controller.
 Assumes the monitor bind and the programmer model are compiled first. */
`timescale 1ns/100ps
module flash_memory_config_byte_tb_top import fcb_pkg::*;;
    localparam int PC = 8; // Short erase-and-program count
    logic clock = 1'b0, rst_b = 1'b0, fetch_en = 1'b0, pin_b = 1'b1, pbuf_we = 1'b0;
    logic par_mode = 1'b0, par_verify = 1'b0, fext, fblk, rv, rdy, done, err, dsm, aux;
    logic [15:0] fetch_addr = '0, baddr;
    logic [6:0] pbuf_addr = '0;
    logic [7:0] pbuf_data = '0, fdata, prd, hsc, d;
    logic [50:0] rb;
    logic [2:0] lvl;
    logic [7:0] mem [int]; // Array model
    logic [7:0] pg [128]; // Page buffer model
    int bad_count = 0, compares = 0, seed = 28651, res, lat, i, cur = 4;
    initial forever #20 clock = ~clock;
    fcb_flash_ctrl #(.PROG_CYC(PC)) dut_u (.clock, .rst_b, .fetch_addr, .fetch_en,
        .fetch_data(fdata), .fetch_external(fext), .fetch_blocked(fblk),
        .external_access_pin_b(pin_b), .req_valid(rv), .req_cmd(rb[50:49]),
        .req_src(rb[48:47]), .req_pc(rb[46:31]), .req_addr(rb[30:15]), .req_data(rb[14:7]),
        .page_idx(rb[6:0]), .req_ready(rdy), .req_done(done), .req_error(err), .pbuf_we,
        .pbuf_addr, .pbuf_data, .par_mode, .par_verify, .par_rdata(prd),
        .hardware_security_config(hsc), .double_speed_mode(dsm), .boot_addr(baddr),
        .aux_ram_enable(aux), .lock_level(lvl));
    fcb_programmer_model prog_u (.clock, .req_ready(rdy), .req_done(done),
        .req_error(err), .req_valid(rv), .req_bus(rb));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic complete_run;
        if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    // Reference for the lock level, highest programmed bit wins
    function automatic logic [2:0] lvl_of(input logic [7:0] c);
        return !c[2] ? 3'h4 : !c[1] ? 3'h3 : !c[0] ? 3'h2 : 3'h1;
    endfunction : lvl_of
    task automatic cfg_chk(input logic [7:0] c);
        chk("config", c, hsc);
        chk("speed", !c[7], dsm);
        chk("boot", c[6] ? 16'h0000 : 16'hF800, baddr);
        chk("auxram", c[3], aux);
        chk("lock", lvl_of(c), lvl);
    endtask : cfg_chk
    task automatic do_reset;
        @(negedge clock);
        rst_b = 1'b0;
        repeat (20) @(negedge clock);
        cfg_chk(CFG_DEFAULT);
        rst_b = 1'b1;
        repeat (2) @(negedge clock);
    endtask : do_reset
    // One request with the refusal and timing predicted beside it
    task automatic req(input logic [1:0] c, s, input logic [15:0] p, a, input logic [7:0] v,
        input logic [6:0] k);
        logic no;
        no = c == 0 || (c == 3 && !(s == 0 && par_mode)) || (s == 0 && c != 3 && cur >= 2)
            || (s == 1 && p < 16'hF800) || (s == 2 && p != ROM_ENTRY_ADDR);
        prog_u.send({c, s, p, a, v, k}, res, lat);
        if (res == 0) begin
            bad_count++;
            complete_run;
        end
        chk("answer", no ? 2 : 1, res[15:0]);
        chk("latency", no ? 1 : PC + 2, lat[15:0]);
        if (!no && c == 1) mem[a] = v;
        if (!no && c == 2) for (i = 0; i < 128; i++) mem[k * 128 + i] = pg[i];
    endtask : req
    task automatic rd(input logic [15:0] a);
        @(negedge clock);
        fetch_addr = a;
        fetch_en = 1'b1;
        @(negedge clock);
        fetch_en = 1'b0;
        chk("fetch", mem[a], fdata);
    endtask : rd
    // Pin low at a given address; from level 2 the pin value latched at reset rules
    task automatic pin_chk(input logic [15:0] a, input logic ext, input logic blk);
        @(negedge clock);
        pin_b = 1'b0;
        fetch_addr = a;
        @(negedge clock);
        chk("external", ext, fext);
        chk("blocked", blk, fblk);
        pin_b = 1'b1;
    endtask : pin_chk
    initial begin
        do_reset;
        par_mode = 1'b1;
        req(3, 0, 0, 0, 8'hF7, 0);
        do_reset;
        cfg_chk(8'hF7);
        cur = 1;
        req(3, 1, 16'hF800, 0, 8'h00, 0);
        req(0, 0, 0, 0, 0, 0);
        req(1, 1, 16'hF7FF, 16'h0010, 8'h5A, 0);
        req(1, 2, 16'hFFEF, 16'h0010, 8'h5A, 0);
        for (i = 0; i < 3; i++) begin
            d = 8'($random(seed));
            req(1, i[1:0], ROM_ENTRY_ADDR, 16'h0020, d, 0);
            rd(16'h0020);
            req(1, i[1:0], ROM_ENTRY_ADDR, 16'h0020, ~d, 0);
            rd(16'h0020);
        end
        for (i = 0; i < 128; i++) begin
            @(negedge clock);
            pg[i] = 8'($random(seed));
            pbuf_we = 1'b1;
            pbuf_addr = i[6:0];
            pbuf_data = pg[i];
        end
        @(negedge clock);
        pbuf_we = 1'b0;
        req(2, 2, ROM_ENTRY_ADDR, 0, 0, 7'h03);
        rd(16'h0180);
        rd(16'h01FF);
        pin_chk(16'h01FF, 1'b1, 1'b0);
        req(3, 0, 0, 0, 8'h3B, 0);
        cfg_chk(8'hF7);
        chk("par read", 8'hF7, prd);
        do_reset;
        cfg_chk(8'h3B);
        cur = 4;
        req(1, 0, 0, 16'h0020, 8'h11, 0);
        pin_chk(16'h01FF, 1'b0, 1'b0);
        pin_chk(16'h8000, 1'b1, 1'b1);
        @(negedge clock);
        par_verify = 1'b1;
        @(negedge clock);
        chk("verify", 8'hFF, prd);
        complete_run;
    end
endmodule : flash_memory_config_byte_tb_top
